// ==== rtl/xfe_core.v ====
// Purpose: execute xor-with-file and the extended literal operations
// Assumes: one 20 MHz clock, four clock cycles make one instruction cycle
// Assumes: program word is valid during phase one at prog_addr
// Assumes: data memory answers a read strobe on the following cycle
// Notes:   other standard opcodes run as a plain one-cycle no-op
//
// Notes on behaviour
// - xor accumulator with addressed file byte
// - destination bit picks accumulator or file
// - bank bit picks access bank or bank select
// - indexed offset when a=0, enabled, f<=95
// - xor updates only negative and zero
// - one word, one cycle, write in phase four
// - extension enabled when fuse unprogrammed
// - fuse bit enables extension and indexed mode
// - eight extended opcodes when extension enabled
// - add/subtract literal to pointer, no flags
// - add select 11 adjusts stack, returns
// - subtract select 11 adjusts stack, returns
// - call target low byte from accumulator
// - indexed source moved to 12-bit file address
// - indexed source moved to indexed destination
// - store literal at stack pointer, then decrement
// - return loads pc from top, second cycle idle
`timescale 1ns/1ps
`include "xfe_regs.vh"

module xfe_core (
  input  wire        clk,
  input  wire        reset,
  input  wire        extension_enable_fuse,
  output reg  [15:0] prog_addr,
  input  wire [15:0] prog_word,
  output reg  [11:0] data_addr,
  output reg  [7:0]  data_wdata,
  output reg         data_we,
  output reg         data_re,
  input  wire [7:0]  data_rdata,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata
);

  // phase of the instruction cycle, one-hot
  localparam PH_Q1 = 4'b0001;
  localparam PH_Q2 = 4'b0010;
  localparam PH_Q3 = 4'b0100;
  localparam PH_Q4 = 4'b1000;

  // what the next instruction cycle does, one-hot
  localparam C2_NONE  = 3'b001;
  localparam C2_FLUSH = 3'b010;
  localparam C2_MOVE  = 3'b100;

  reg  [3:0]  phase;          // current phase
  reg  [2:0]  cyc2;           // kind of the coming cycle
  reg  [15:0] ir;             // instruction word being executed
  reg  [15:0] word2;          // second word of a move
  reg  [7:0]  acc;            // accumulator_register
  reg  [7:0]  bank;           // bank_select_register
  reg  [7:0]  status;         // status flags
  reg  [11:0] ptr [0:2];      // indirect_pointer set, 2 is the stack one
  reg  [7:0]  call_hi;        // upper target byte for calls
  reg         run;            // core runs while set
  reg         ext_en;         // latched extension_enable_fuse
  reg         fuse_loaded;    // fuse has been sampled
  reg  [7:0]  alu;            // xor result held for phase four
  reg  [7:0]  mov_data;       // byte carried by a move
  reg  [15:0] rstack [0:7];   // return stack
  reg  [2:0]  rsp;            // next free return stack slot

  wire [7:0]  f_addr;         // 8-bit file address field
  wire        bank_bit;       // bank select bit of the opcode
  wire        dest_bit;       // destination bit of the opcode
  wire [1:0]  sel;            // pointer select field
  wire [11:0] k6;             // 6-bit literal widened
  wire [2:0]  rsp_top;        // slot holding top_of_return_stack
  wire [15:0] top_of_return_stack;
  wire [11:0] sp;             // software_stack_pointer
  wire        is_xor;         // xor_accumulator_with_file
  wire        is_add;         // add_literal_to_pointer family
  wire        is_sub;         // subtract_literal_from_pointer family
  wire        is_push;        // push_literal
  wire        is_move;        // move_indexed_to_file / _to_indexed
  wire        is_call;        // call_via_accumulator
  wire        idx_mode;       // indexed literal offset addressing
  reg  [11:0] xor_addr;       // full address of the xor operand
  wire [11:0] src_addr;       // move source address
  wire [11:0] dst_addr;       // move destination address
  wire [15:0] pc_next;        // sequential fetch address
  wire [15:0] dec_word;       // word decoded in the current phase

  // phase one decodes the word on the program bus, so the operand
  // read can go out in phase two and its answer is back in phase three
  assign dec_word = (phase == PH_Q1) ? prog_word : ir;
  assign f_addr   = dec_word[7:0];
  assign bank_bit = dec_word[8];
  assign dest_bit = dec_word[9];
  assign sel      = dec_word[7:6];
  assign k6       = {6'h00, dec_word[5:0]};
  assign rsp_top  = rsp - 3'h1;
  assign top_of_return_stack = rstack[rsp_top];
  assign sp       = ptr[2];
  assign pc_next  = prog_addr + `XFE_PC_STEP;

  // opcode recognition
  // xor opcode match
  assign is_xor  = (dec_word[15:10] == `XFE_OP_XOR);
  assign is_add  = ext_en & (dec_word[15:8] == `XFE_OP_PTR_ADD);
  assign is_sub  = ext_en & (dec_word[15:8] == `XFE_OP_PTR_SUB);
  assign is_push = ext_en & (dec_word[15:8] == `XFE_OP_PUSH);
  assign is_move = ext_en & (dec_word[15:8] == `XFE_OP_MOVE);
  assign is_call = ext_en & (dec_word == `XFE_OP_CALL);

  assign idx_mode = ~bank_bit & ext_en & (f_addr <= `XFE_IDX_LIMIT);

  // operand address of the xor opcode
  always @* begin
    if (bank_bit) begin
      xor_addr = {bank[3:0], f_addr};
    end else if (idx_mode) begin
      xor_addr = sp + {4'h0, f_addr};
    end else if (f_addr <= `XFE_IDX_LIMIT) begin
      xor_addr = {4'h0, f_addr};
    end else begin
      // access bank, special-register half
      xor_addr = {`XFE_ACCESS_HI, f_addr};
    end
  end

  assign src_addr = sp + {5'h00, dec_word[6:0]};
  assign dst_addr = ir[7] ? (sp + {5'h00, word2[6:0]}) : word2[11:0];

  // software read port, data only in the cycle after the strobe
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= `XFE_RST_BYTE;
    end else if (reg_read) begin
      case (reg_addr)
        `XFE_REG_ACC:     reg_rdata <= acc;
        `XFE_REG_BANK:    reg_rdata <= bank;
        `XFE_REG_STATUS:  reg_rdata <= status;
        `XFE_REG_PTR0_LO: reg_rdata <= ptr[0][7:0];
        `XFE_REG_PTR0_HI: reg_rdata <= {4'h0, ptr[0][11:8]};
        `XFE_REG_PTR1_LO: reg_rdata <= ptr[1][7:0];
        `XFE_REG_PTR1_HI: reg_rdata <= {4'h0, ptr[1][11:8]};
        `XFE_REG_PTR2_LO: reg_rdata <= ptr[2][7:0];
        `XFE_REG_PTR2_HI: reg_rdata <= {4'h0, ptr[2][11:8]};
        `XFE_REG_CTRL:    reg_rdata <= {6'h00, ext_en, run};
        `XFE_REG_PC_LO:   reg_rdata <= prog_addr[7:0];
        `XFE_REG_PC_HI:   reg_rdata <= prog_addr[15:8];
        `XFE_REG_CALL_HI: reg_rdata <= call_hi;
        `XFE_REG_RSP:     reg_rdata <= {5'h00, rsp};
        default:          reg_rdata <= `XFE_RST_BYTE;
      endcase
    end else begin
      // nothing outside the answer cycle
      reg_rdata <= `XFE_RST_BYTE;
    end
  end

  // return stack storage, written by calls only
  always @(posedge clk) begin
    if (run && phase == PH_Q4 && cyc2 == C2_NONE && is_call) begin
      rstack[rsp] <= pc_next;
    end
  end

  // phase sequencer, execute datapath and software writes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      phase       <= PH_Q1;
      cyc2        <= C2_NONE;
      ir          <= `XFE_RST_WORD;
      word2       <= `XFE_RST_WORD;
      acc         <= `XFE_RST_BYTE;
      bank        <= `XFE_RST_BYTE;
      status      <= `XFE_RST_BYTE;
      ptr[0]      <= `XFE_RST_PTR;
      ptr[1]      <= `XFE_RST_PTR;
      ptr[2]      <= `XFE_RST_PTR;
      call_hi     <= `XFE_RST_BYTE;
      run         <= 1'b0;
      ext_en      <= 1'b1;
      fuse_loaded <= 1'b0;
      alu         <= `XFE_RST_BYTE;
      mov_data    <= `XFE_RST_BYTE;
      rsp         <= 3'h0;
      prog_addr   <= `XFE_RST_PC;
      data_addr   <= `XFE_RST_PTR;
      data_wdata  <= `XFE_RST_BYTE;
      data_we     <= 1'b0;
      data_re     <= 1'b0;
    end else begin
      // strobes last one cycle
      data_we <= 1'b0;
      data_re <= 1'b0;
      if (!fuse_loaded) begin
        ext_en      <= extension_enable_fuse;
        fuse_loaded <= 1'b1;
      end
      // software writes; core updates below take priority
      if (reg_write) begin
        case (reg_addr)
          `XFE_REG_ACC:     acc <= reg_wdata;
          `XFE_REG_BANK:    bank <= reg_wdata;
          `XFE_REG_STATUS:  status <= reg_wdata;
          `XFE_REG_PTR0_LO: ptr[0][7:0] <= reg_wdata;
          `XFE_REG_PTR0_HI: ptr[0][11:8] <= reg_wdata[3:0];
          `XFE_REG_PTR1_LO: ptr[1][7:0] <= reg_wdata;
          `XFE_REG_PTR1_HI: ptr[1][11:8] <= reg_wdata[3:0];
          `XFE_REG_PTR2_LO: ptr[2][7:0] <= reg_wdata;
          `XFE_REG_PTR2_HI: ptr[2][11:8] <= reg_wdata[3:0];
          `XFE_REG_CTRL:    run <= reg_wdata[`XFE_CTRL_RUN];
          `XFE_REG_PC_LO:   prog_addr[7:0] <= reg_wdata;
          `XFE_REG_PC_HI:   prog_addr[15:8] <= reg_wdata;
          `XFE_REG_CALL_HI: call_hi <= reg_wdata;
          default:          run <= run;
        endcase
      end
      if (run) begin
        case (phase)
          PH_Q1: begin
            // decode: take the fetched word, start the operand read
            if (cyc2 == C2_NONE) begin
              ir <= prog_word;
              if (is_xor) begin
                data_addr <= xor_addr;
                data_re   <= 1'b1;
              end else if (is_move) begin
                data_addr <= src_addr;
                data_re   <= 1'b1;
              end
            end else if (cyc2 == C2_MOVE) begin
              word2 <= prog_word;
            end
            phase <= PH_Q2;
          end
          PH_Q2: begin
            // operand read strobe is out during this phase
            phase <= PH_Q3;
          end
          PH_Q3: begin
            // process data; file writes go out for phase four
            if (cyc2 == C2_NONE && is_xor) begin
              alu <= acc ^ data_rdata;
              if (dest_bit) begin
                data_wdata <= acc ^ data_rdata;
                data_we    <= 1'b1;
              end
            end else if (cyc2 == C2_NONE && is_move) begin
              mov_data <= data_rdata;
            end else if (cyc2 == C2_NONE && is_push) begin
              data_addr  <= sp;
              data_wdata <= ir[7:0];
              data_we    <= 1'b1;
            end else if (cyc2 == C2_MOVE) begin
              data_addr  <= dst_addr;
              data_wdata <= mov_data;
              data_we    <= 1'b1;
            end
            phase <= PH_Q4;
          end
          PH_Q4: begin
            phase <= PH_Q1;
            case (cyc2)
              C2_NONE: begin
                prog_addr <= pc_next;
                if (is_xor) begin
                  if (!dest_bit) begin
                    acc <= alu;
                  end
                  status[`XFE_ST_N] <= alu[7];
                  status[`XFE_ST_Z] <= (alu == 8'h00);
                end else if (is_add || is_sub) begin
                  if (sel == `XFE_SEL_STACK) begin
                    ptr[2] <= is_add ? sp + k6 : sp - k6;
                    prog_addr <= top_of_return_stack;
                    rsp       <= rsp_top;
                    cyc2      <= C2_FLUSH;
                  end else begin
                    ptr[sel] <= is_add ? ptr[sel] + k6 : ptr[sel] - k6;
                  end
                end else if (is_call) begin
                  prog_addr <= {call_hi, acc};
                  rsp       <= rsp + 3'h1;
                  cyc2      <= C2_FLUSH;
                end else if (is_move) begin
                  cyc2 <= C2_MOVE;
                end else if (is_push) begin
                  ptr[2] <= sp - 12'h001;
                end
              end
              C2_FLUSH: begin
                cyc2 <= C2_NONE;
              end
              C2_MOVE: begin
                // skip past the second word
                prog_addr <= pc_next;
                cyc2      <= C2_NONE;
              end
              default: begin
                cyc2 <= C2_NONE;
              end
            endcase
          end
          default: begin
            phase <= PH_Q1;
          end
        endcase
      end
    end
  end

endmodule

// ==== rtl/xfe_regs.vh ====
// Purpose: constants for the xor and extended-operation execute block
// Assumes: included by rtl/xfe_core.v only
// Notes:   offsets are on the software register port, 4-bit address
`ifndef XFE_REGS_VH
`define XFE_REGS_VH

// software register offsets
`define XFE_REG_ACC      4'h0
`define XFE_REG_BANK     4'h1
`define XFE_REG_STATUS   4'h2
`define XFE_REG_PTR0_LO  4'h3
`define XFE_REG_PTR0_HI  4'h4
`define XFE_REG_PTR1_LO  4'h5
`define XFE_REG_PTR1_HI  4'h6
`define XFE_REG_PTR2_LO  4'h7
`define XFE_REG_PTR2_HI  4'h8
`define XFE_REG_CTRL     4'h9
`define XFE_REG_PC_LO    4'ha
`define XFE_REG_PC_HI    4'hb
`define XFE_REG_CALL_HI  4'hc
`define XFE_REG_RSP      4'hd

// control register fields
`define XFE_CTRL_RUN     0
`define XFE_CTRL_EXT     1

// status register fields
`define XFE_ST_N         4
`define XFE_ST_Z         2

// reset values
`define XFE_RST_BYTE     8'h00
`define XFE_RST_PTR      12'h000
`define XFE_RST_PC       16'h0000
`define XFE_RST_WORD     16'h0000

// opcode patterns
`define XFE_OP_XOR       6'h06
`define XFE_OP_PTR_ADD   8'he8
`define XFE_OP_PTR_SUB   8'he9
`define XFE_OP_PUSH      8'hea
`define XFE_OP_MOVE      8'heb
`define XFE_OP_CALL      16'h0014
`define XFE_SEL_STACK    2'h3

// addressing limits and fetch step
`define XFE_IDX_LIMIT    8'h5f
`define XFE_ACCESS_HI    4'hf
`define XFE_PC_STEP      16'h0002

`endif

// ==== testbench/xfe_core_sva.sv ====
// Purpose: port assertions for the execute block
// Assumes: fuse held steady between resets, pc not written by software
// Notes:   bound to xfe_core below the module
`timescale 1ns/1ps
module xfe_core_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        extension_enable_fuse,
  input wire logic [15:0] prog_addr,
  input wire logic        data_we,
  input wire logic        data_re,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata
);
  logic fuse_q;   // fuse level taken after release
  logic first;    // high until first edge after release
  logic run_seen; // run bit has been written with a one
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // capture fuse once and note the first run request
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      first <= 1'b1;
      fuse_q <= 1'b0;
      run_seen <= 1'b0;
    end else begin
      first <= 1'b0;
      if (first)
        fuse_q <= extension_enable_fuse;
      if (reg_write && reg_addr == 4'h9 && reg_wdata[0])
        run_seen <= 1'b1;
    end
  end
  // bank write, idle edge, bank read
  sequence bank_wr_rd;
    reg_write && reg_addr == 4'h1 ##1 !reg_write
      ##1 reg_read && reg_addr == 4'h1;
  endsequence
  a_we_spacing: assert property (
    data_we |=> !data_we [*3]) else $error("data writes too close");
  a_re_spacing: assert property (
    data_re |=> !data_re [*3]) else $error("data reads too close");
  a_re_we_apart: assert property (
    data_re |-> !data_we ##1 (!data_we && !data_re))
    else $error("write not held to fourth phase");
  a_pc_hold: assert property (
    $changed(prog_addr) |=> $stable(prog_addr) [*3])
    else $error("fetch address moved inside a cycle");
  a_idle_quiet: assert property (
    !run_seen |-> !data_re && !data_we) else $error("access while idle");
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data stray");
  a_unmapped_zero: assert property (
    reg_read && reg_addr > 4'hd |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bank_readback: assert property (
    bank_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("bank select readback wrong");
  a_ext_flag: assert property (
    reg_read && reg_addr == 4'h9 |=> reg_rdata[1] == fuse_q)
    else $error("extension flag differs from fuse");
endmodule

bind xfe_core xfe_core_sva chk_u (
  .clk                   (clk),
  .reset                 (reset),
  .extension_enable_fuse (extension_enable_fuse),
  .prog_addr             (prog_addr),
  .data_we               (data_we),
  .data_re               (data_re),
  .reg_addr              (reg_addr),
  .reg_wdata             (reg_wdata),
  .reg_write             (reg_write),
  .reg_read              (reg_read),
  .reg_rdata             (reg_rdata)
);

// ==== testbench/xfe_mem.sv ====
// Purpose: program and data memory on the far side of the core
// Assumes: word index is prog_addr bits 8:1
// Notes:   read byte valid only the cycle after a read strobe
`timescale 1ns/1ps
module xfe_mem (
  input  wire logic        clk,
  input  wire logic [15:0] prog_addr,
  output wire logic [15:0] prog_word,
  input  wire logic [11:0] data_addr,
  input  wire logic [7:0]  data_wdata,
  input  wire logic        data_we,
  input  wire logic        data_re,
  output      logic [7:0]  data_rdata
);
  logic [15:0] pmem [0:255];  // program words
  logic [7:0]  dmem [0:4095]; // data bytes
  // word follows the fetch address at once
  assign prog_word = pmem[prog_addr[8:1]];
  // write in place, answer reads next cycle, else toggle the bus
  always @(posedge clk) begin
    if (data_we)
      dmem[data_addr] <= data_wdata;
    if (data_re)
      data_rdata <= dmem[data_addr];
    else
      data_rdata <= ~data_rdata;
  end
  // no-op words everywhere at start
  initial begin
    data_rdata = 8'h00;
    for (int i = 0; i < 256; i++)
      pmem[i] = 16'hffff;
  end
endmodule

// ==== testbench/xfe_core_tb.sv ====
// Purpose: self-checking bench for the execute block
// Assumes: registers and memory preloaded while the core is stopped
// Notes:   expectations worked out with plain integers
`timescale 1ns/1ps
module xfe_core_tb;
  logic        clk = 1'b0;        // core clock
  logic        reset = 1'b1;      // async reset
  logic        fuse = 1'b1;       // extension fuse level
  logic [15:0] prog_addr;         // fetch address
  logic [15:0] prog_word;         // fetched word
  logic [11:0] data_addr;         // data address
  logic [7:0]  data_wdata;        // data write byte
  logic        data_we;           // data write strobe
  logic        data_re;           // data read strobe
  logic [7:0]  data_rdata;        // data read byte
  logic [3:0]  reg_addr = 4'h0;   // register address
  logic [7:0]  reg_wdata = 8'h00; // register write byte
  logic        reg_write = 1'b0;  // register write strobe
  logic        reg_read = 1'b0;   // register read strobe
  logic [7:0]  reg_rdata;         // register read byte
  int          n_errors = 0;      // mismatches
  int          total_checks = 0;  // comparisons made
  int          cycles = 0;        // clock count
  int          seed;              // random seed
  int          acc, acc2, p0, m1, m2, m3, r; // model values
  always #25 clk = ~clk;
  xfe_core dut_u (.clk(clk), .reset(reset), .extension_enable_fuse(fuse),
    .prog_addr(prog_addr), .prog_word(prog_word), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_we(data_we), .data_re(data_re),
    .data_rdata(data_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  xfe_mem mem_u (.clk(clk), .prog_addr(prog_addr), .prog_word(prog_word),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we),
    .data_re(data_re), .data_rdata(data_rdata));
  // count and report one comparison
  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one register write cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // register read, data taken in the answer cycle
  task automatic chk_reg(input string nm, input logic [3:0] a,
                         input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    cmp(nm, e, reg_rdata);
  endtask
  // data memory byte against the model
  task automatic chk_mem(input string nm, input logic [11:0] a, input int e);
    cmp(nm, e[7:0], mem_u.dmem[a]);
  endtask
  task automatic do_reset(input logic f);
    @(posedge clk);
    fuse <= f;
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
  endtask
  // program words, rest filled with no-ops
  task automatic load(input logic [15:0] w[$]);
    for (int i = 0; i < 16; i++)
      mem_u.pmem[i] = (i < w.size()) ? w[i] : 16'hffff;
  endtask
  // n instruction cycles of four clocks, stopping on a cycle boundary
  task automatic run(input int n);
    wr(4'h9, 8'h01);
    repeat (4 * n - 2) @(posedge clk);
    wr(4'h9, 8'h00);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    seed = 32'h874ec343;
    do_reset(1'b1);
    chk_reg("ctrl", 4'h9, 8'h02);
    chk_reg("unmapped", 4'he, 8'h00);
    acc = $random(seed) & 255;
    p0 = $random(seed) & 4095;
    m1 = $random(seed) & 255;
    m2 = $random(seed) & 255;
    m3 = $random(seed) & 255;
    mem_u.dmem[12'hf60] = m1[7:0];
    mem_u.dmem[12'h210] = m2[7:0];
    mem_u.dmem[12'h105] = m3[7:0];
    wr(4'h0, acc[7:0]);
    wr(4'h1, 8'h02);
    chk_reg("bank", 4'h1, 8'h02);
    wr(4'h3, p0[7:0]);
    wr(4'h4, {4'h0, p0[11:8]});
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h01);
    load({16'h1a60, 16'h1910, 16'h1a05, 16'hea5c, 16'he8a3, 16'he93f});
    run(8);
    acc2 = acc ^ m2;
    r = m3 ^ acc2;
    chk_mem("xor to file", 12'hf60, m1 ^ acc);
    chk_mem("banked file", 12'h210, m2);
    chk_reg("acc", 4'h0, acc2[7:0]);
    chk_mem("indexed file", 12'h105, r);
    chk_reg("status", 4'h2, {3'h0, r[7], 1'b0, r == 0, 2'h0});
    chk_mem("pushed byte", 12'h100, 8'h5c);
    chk_reg("ptr2 lo", 4'h7, 8'h22);
    chk_reg("ptr2 hi", 4'h8, 8'h01);
    r = (p0 - 63) & 4095;
    chk_reg("ptr0 lo", 4'h3, r[7:0]);
    chk_reg("ptr0 hi", 4'h4, {4'h0, r[11:8]});
    do_reset(1'b0);
    chk_reg("ctrl", 4'h9, 8'h00);
    mem_u.dmem[12'h005] = m1[7:0];
    mem_u.dmem[12'h205] = m2[7:0];
    mem_u.dmem[12'h200] = m3[7:0];
    wr(4'h0, acc[7:0]);
    wr(4'h8, 8'h02);
    load({16'h1a05, 16'hea77, 16'he8a3, 16'h0014});
    run(8);
    chk_mem("access file", 12'h005, m1 ^ acc);
    chk_mem("no indexed", 12'h205, m2);
    chk_mem("no push", 12'h200, m3);
    chk_reg("ptr2 lo", 4'h7, 8'h00);
    chk_reg("ptr2 hi", 4'h8, 8'h02);
    // calls, both returns and both moves with the extension on
    do_reset(1'b1);
    mem_u.dmem[12'h309] = m1[7:0];
    mem_u.dmem[12'h306] = m2[7:0];
    mem_u.dmem[12'h040] = 8'h04;
    wr(4'h0, 8'h10);
    wr(4'h8, 8'h03);
    load({16'h0014, 16'heb05, 16'hf2a0, 16'heb82, 16'hf007, 16'h1940,
          16'h0014, 16'hffff, 16'he8c4, 16'hffff, 16'he9c1});
    run(13);
    chk_mem("file move", 12'h2a0, m1);
    chk_mem("indexed move", 12'h30b, m2);
    chk_reg("acc target", 4'h0, 8'h14);
    chk_reg("ptr2 lo", 4'h7, 8'h03);
    chk_reg("ptr2 hi", 4'h8, 8'h03);
    chk_reg("pc lo", 4'ha, 8'h0e);
    chk_reg("pc hi", 4'hb, 8'h00);
    chk_reg("ret depth", 4'hd, 8'h00);
    finish_test();
  end
endmodule
